// ===== core/asq_conv.sv
// One sample-and-hold plus converter port: steers the selector, waits for data
`default_nettype none
`include "asq_map.svh"
module asq_conv #(
  parameter int DATA_W = `ASQ_RES_W
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Sequencer side
  asq_res_if.conv                req,
  // Analog side
  output logic [2:0]             sel_o,
  output logic                   sample_o,
  input  wire logic              done_i,
  input  wire logic [DATA_W-1:0] data_i
);
  import asq_pkg::*;

  if (DATA_W != `ASQ_RES_W) begin : g_bad_width
    $error("asq_conv: DATA_W must match the result width");
  end

  asq_conv_s s;
  asq_conv_s next_s;

  always_comb begin
    next_s = s;
    next_s.sample = 1'b0;
    next_s.valid = 1'b0;
    // A start while busy is dropped; the sequencer never issues one
    if (!s.busy && req.start) begin
      next_s.busy = 1'b1;
      next_s.sample = 1'b1;
      next_s.sel = req.ch;
      next_s.slot = req.slot;
    end else if (s.busy && done_i) begin
      next_s.busy = 1'b0;
      next_s.valid = 1'b1;
      next_s.data = data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sel_o = s.sel;
  assign sample_o = s.sample;
  assign req.valid = s.valid;
  assign req.rslot = s.slot;
  assign req.data = s.data;
endmodule : asq_conv
`default_nettype wire

// ===== core/asq_eval.sv
// Limit and zero-crossing check of one fresh result against its slot settings
`default_nettype none
`include "asq_map.svh"
module asq_eval (
  // Fresh result and the slot's previous result
  input  wire asq_pkg::asq_res_t cur_i,
  input  wire asq_pkg::asq_res_t prev_i,
  // Slot settings
  input  wire asq_pkg::asq_res_t low_i,
  input  wire asq_pkg::asq_res_t high_i,
  input  wire logic [1:0]        zc_i,
  // Verdicts
  output logic                   below_o,
  output logic                   above_o,
  output logic                   cross_o
);
  import asq_pkg::*;

  logic cur_pos;
  logic prev_pos;

  always_comb begin
    cur_pos = cur_i >= `ASQ_MIDSCALE;
    prev_pos = prev_i >= `ASQ_MIDSCALE;
    below_o = cur_i < low_i;
    above_o = cur_i > high_i;
    unique case (asq_zc_e'(zc_i))
      ASQ_ZC_OFF:  cross_o = 1'b0;
      ASQ_ZC_FALL: cross_o = prev_pos && !cur_pos;
      ASQ_ZC_RISE: cross_o = !prev_pos && cur_pos;
      ASQ_ZC_ANY:  cross_o = prev_pos != cur_pos;
    endcase
  end
endmodule : asq_eval
`default_nettype wire

// ===== core/asq_map.svh
// Register offsets, field positions, reset values and counts of the scan sequencer
`ifndef ASQ_MAP_SVH
`define ASQ_MAP_SVH

// ***************************************************
// Register byte offsets
// ***************************************************
`define ASQ_OFF_CTRL   8'h00
`define ASQ_OFF_STAT   8'h04
`define ASQ_OFF_ISR    8'h08
`define ASQ_OFF_IMR    8'h0C
`define ASQ_OFF_LIST   8'h10
`define ASQ_OFF_ZCSEL  8'h14
`define ASQ_OFF_LIMLO  8'h18
`define ASQ_OFF_LIMHI  8'h1C
`define ASQ_OFF_ZCST   8'h20
`define ASQ_BANK_RES   8'h40
`define ASQ_BANK_LOW   8'h60
`define ASQ_BANK_HIGH  8'h80

// ***************************************************
// Field positions
// ***************************************************
`define ASQ_CTRL_MODE  0
`define ASQ_CTRL_SIM   2
`define ASQ_CTRL_GO    4
`define ASQ_CTRL_STOP  5
`define ASQ_CTRL_LEN   8
`define ASQ_STAT_BUSY  0
`define ASQ_STAT_ARM   1
`define ASQ_ISR_DONE   0
`define ASQ_ISR_LIM    1
`define ASQ_ISR_ZC     2

// ***************************************************
// Reset values and counts
// ***************************************************
`define ASQ_RST_LIST   24'hFAC688
`define ASQ_RST_LOW    12'h000
`define ASQ_RST_HIGH   12'hFFF
`define ASQ_MIDSCALE   12'h800
`define ASQ_RES_W      12
`define ASQ_NUM_CH     8
`define ASQ_HALF_CH    3'h4

`endif

// ===== core/asq_pkg.sv
// Types shared by the scan sequencer modules
`default_nettype none
`include "asq_map.svh"
package asq_pkg;
  typedef logic [`ASQ_RES_W-1:0] asq_res_t;
  typedef enum logic [2:0] {ASQ_IDLE, ASQ_ARMED, ASQ_START, ASQ_WAIT,
                            ASQ_END} asq_state_e;
  typedef enum logic [1:0] {ASQ_ONCE = 2'h0, ASQ_TRIG = 2'h1,
                            ASQ_LOOP = 2'h2} asq_mode_e;
  typedef enum logic [1:0] {ASQ_ZC_OFF = 2'h0, ASQ_ZC_FALL = 2'h1,
                            ASQ_ZC_RISE = 2'h2, ASQ_ZC_ANY = 2'h3} asq_zc_e;
  typedef struct packed {
    logic     busy;
    logic     sample;
    logic     valid;
    logic [2:0] sel;
    logic [2:0] slot;
    asq_res_t data;
  } asq_conv_s;
endpackage : asq_pkg
`default_nettype wire

// ===== core/asq_res_if.sv
// Request and result carrier between sequencer and one converter port
`default_nettype none
interface asq_res_if;
  import asq_pkg::*;
  logic     start;
  logic [2:0] ch;
  logic [2:0] slot;
  logic     valid;
  logic [2:0] rslot;
  asq_res_t data;
  modport conv (input start, ch, slot, output valid, rslot, data);
  modport ctl  (output start, ch, slot, input valid, rslot, data);
endinterface : asq_res_if
`default_nettype wire

// ===== core/asq_top.sv
// Scan sequencer for the dual sample-and-hold converter, Wishbone slave
//
// What this block does
// - One eight-input selector feeds two sample-and-hold ports, each with its own 12-bit converter, and every result lands in a readable buffer.
// - Three scan modes: one scan then halt, one scan per trigger, or scans repeated until software stops them.
// - In sequential mode up to eight inputs are sampled in the order held in the channel list.
// - In sequential mode each entry goes to whichever converter serves its input, so one or both get used.
// - In simultaneous mode both sample-and-hold ports start in the same cycle on two inputs.
// - At scan end an enabled interrupt flags any reading below its low limit or above its high limit.
// - An enabled interrupt flags the selected zero-crossing condition of any result.
`default_nettype none
`include "asq_map.svh"
module asq_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Scan trigger
  input  wire logic        trig_i,
  // Converter ports
  output logic [2:0]       sh_a_ch_o,
  output logic             sh_a_sample_o,
  input  wire logic        adc_a_done_i,
  input  wire asq_pkg::asq_res_t adc_a_data_i,
  output logic [2:0]       sh_b_ch_o,
  output logic             sh_b_sample_o,
  input  wire logic        adc_b_done_i,
  input  wire asq_pkg::asq_res_t adc_b_data_i,
  // Interrupt
  output logic             irq_o
);
  import asq_pkg::*;

  // ***************************************************
  // State
  // ***************************************************
  typedef struct packed {
    asq_state_e       st;
    logic [1:0]       mode;
    logic             simult;
    logic [2:0]       len;
    logic [7:0][2:0]  list;
    logic [7:0][1:0]  zcsel;
    logic [2:0]       isr;
    logic [2:0]       imr;
    logic [7:0]       limlo;
    logic [7:0]       limhi;
    logic [7:0]       zcst;
    logic [7:0][`ASQ_RES_W-1:0] result;
    logic [7:0][`ASQ_RES_W-1:0] low;
    logic [7:0][`ASQ_RES_W-1:0] high;
    logic [2:0]       step;
    logic [1:0]       pend;
    logic             stop_req;
    logic             out_hit;
    logic             zc_hit;
    logic             trig_q;
    logic [1:0]       start;
    logic [1:0][2:0]  start_ch;
    logic [1:0][2:0]  start_slot;
    logic             ack;
    logic [31:0]      rdat;
    logic             irq;
  } asq_top_s;

  asq_top_s s;
  asq_top_s next_s;

  // ***************************************************
  // Helpers
  // ***************************************************
  function automatic logic in_bank(input logic [7:0] adr,
                                   input logic [7:0] base);
    in_bank = adr[7:5] == base[7:5];
  endfunction : in_bank

  function automatic logic [31:0] lanes(input logic [3:0] sel);
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lanes

  // ***************************************************
  // Converter ports and result checks
  // ***************************************************
  asq_res_if res_if[2] ();
  logic [1:0][2:0] sel_w;
  logic [1:0]      sample_w;
  logic [1:0]      done_w;
  asq_res_t        data_w [2];
  logic [1:0]      below_w;
  logic [1:0]      above_w;
  logic [1:0]      cross_w;
  logic [1:0]      rvalid_w;
  logic [1:0][2:0] rslot_w;
  asq_res_t        rdata_w [2];

  assign done_w = {adc_b_done_i, adc_a_done_i};
  assign data_w[0] = adc_a_data_i;
  assign data_w[1] = adc_b_data_i;

  for (genvar g = 0; g < 2; g++) begin : g_port
    assign res_if[g].start = s.start[g];
    assign res_if[g].ch = s.start_ch[g];
    assign res_if[g].slot = s.start_slot[g];
    assign rvalid_w[g] = res_if[g].valid;
    assign rslot_w[g] = res_if[g].rslot;
    assign rdata_w[g] = res_if[g].data;

    asq_conv #(
      .DATA_W   (`ASQ_RES_W)
    ) u_conv (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .req      (res_if[g]),
      .sel_o    (sel_w[g]),
      .sample_o (sample_w[g]),
      .done_i   (done_w[g]),
      .data_i   (data_w[g])
    );

    asq_eval u_eval (
      .cur_i    (rdata_w[g]),
      .prev_i   (s.result[rslot_w[g]]),
      .low_i    (s.low[rslot_w[g]]),
      .high_i   (s.high[rslot_w[g]]),
      .zc_i     (s.zcsel[rslot_w[g]]),
      .below_o  (below_w[g]),
      .above_o  (above_w[g]),
      .cross_o  (cross_w[g])
    );
  end

  // ***************************************************
  // Next state
  // ***************************************************
  logic        wr;
  logic        go;
  logic        stop;
  logic        last;
  logic [2:0]  ch;
  logic [2:0]  idx_b;
  logic [2:0]  widx;
  logic [31:0] m;
  logic [31:0] d;

  always_comb begin
    next_s = s;
    next_s.start = 2'h0;
    next_s.trig_q = trig_i;
    widx = wb_adr_i[4:2];
    m = lanes(wb_sel_i);
    d = wb_dat_i & m;
    // Writes land on the edge that ends the ack cycle, one edge after ack shows to the master
    wr = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;
    go = wr && wb_adr_i == `ASQ_OFF_CTRL && d[`ASQ_CTRL_GO];
    stop = wr && wb_adr_i == `ASQ_OFF_CTRL && d[`ASQ_CTRL_STOP];
    ch = s.list[s.step];
    idx_b = 3'(s.step + `ASQ_HALF_CH);
    last = s.simult ? s.step[1:0] == s.len[1:0] : s.step == s.len;

    // Register writes
    if (wr) begin
      unique case (wb_adr_i)
        `ASQ_OFF_CTRL: begin
          if (wb_sel_i[0]) begin
            next_s.mode = wb_dat_i[`ASQ_CTRL_MODE +: 2];
            next_s.simult = wb_dat_i[`ASQ_CTRL_SIM];
          end
          if (wb_sel_i[1]) begin
            next_s.len = wb_dat_i[`ASQ_CTRL_LEN +: 3];
          end
        end
        `ASQ_OFF_IMR:   next_s.imr = (s.imr & ~m[2:0]) | d[2:0];
        `ASQ_OFF_LIST:  next_s.list = (s.list & ~m[23:0]) | d[23:0];
        `ASQ_OFF_ZCSEL: next_s.zcsel = (s.zcsel & ~m[15:0]) | d[15:0];
        `ASQ_OFF_ISR:   next_s.isr = s.isr & ~d[2:0];
        `ASQ_OFF_LIMLO: next_s.limlo = s.limlo & ~d[7:0];
        `ASQ_OFF_LIMHI: next_s.limhi = s.limhi & ~d[7:0];
        `ASQ_OFF_ZCST:  next_s.zcst = s.zcst & ~d[7:0];
        default: begin
          if (in_bank(wb_adr_i, `ASQ_BANK_LOW)) begin
            next_s.low[widx] = (s.low[widx] & ~m[11:0]) | d[11:0];
          end else if (in_bank(wb_adr_i, `ASQ_BANK_HIGH)) begin
            next_s.high[widx] = (s.high[widx] & ~m[11:0]) | d[11:0];
          end
        end
      endcase
    end

    // Results: buffer slot, limits and crossings; set wins over clear
    for (int p = 0; p < 2; p++) begin
      if (rvalid_w[p] && s.pend[p]) begin
        next_s.pend[p] = 1'b0;
        next_s.result[rslot_w[p]] = rdata_w[p];
        if (below_w[p]) begin
          next_s.limlo[rslot_w[p]] = 1'b1;
          next_s.out_hit = 1'b1;
        end
        if (above_w[p]) begin
          next_s.limhi[rslot_w[p]] = 1'b1;
          next_s.out_hit = 1'b1;
        end
        if (cross_w[p]) begin
          next_s.zcst[rslot_w[p]] = 1'b1;
          next_s.zc_hit = 1'b1;
        end
      end
    end

    // Scan sequence
    unique case (s.st)
      ASQ_IDLE: begin
        if (go) begin
          next_s.stop_req = 1'b0;
          next_s.step = 3'h0;
          // A mode written together with GO already decides this start
          next_s.st = next_s.mode == ASQ_TRIG ? ASQ_ARMED : ASQ_START;
        end
      end
      ASQ_ARMED: begin
        if (stop) begin
          next_s.st = ASQ_IDLE;
        end else if (trig_i && !s.trig_q) begin
          next_s.step = 3'h0;
          next_s.st = ASQ_START;
        end
      end
      ASQ_START: begin
        if (s.simult) begin
          // Both ports sample in the same cycle
          next_s.start = 2'h3;
          next_s.start_ch[0] = ch;
          next_s.start_slot[0] = s.step;
          next_s.start_ch[1] = s.list[idx_b];
          next_s.start_slot[1] = idx_b;
          next_s.pend = 2'h3;
        end else begin
          // Inputs 0-3 belong to port A, 4-7 to port B
          next_s.start[ch[2]] = 1'b1;
          next_s.start_ch[ch[2]] = ch;
          next_s.start_slot[ch[2]] = s.step;
          next_s.pend[ch[2]] = 1'b1;
        end
        next_s.st = ASQ_WAIT;
      end
      ASQ_WAIT: begin
        if (next_s.pend == 2'h0) begin
          next_s.st = last ? ASQ_END : ASQ_START;
          next_s.step = last ? s.step : 3'(s.step + 3'h1);
        end
      end
      ASQ_END: begin
        next_s.isr[`ASQ_ISR_DONE] = 1'b1;
        next_s.isr[`ASQ_ISR_LIM] = next_s.isr[`ASQ_ISR_LIM] | s.out_hit;
        next_s.isr[`ASQ_ISR_ZC] = next_s.isr[`ASQ_ISR_ZC] | s.zc_hit;
        next_s.out_hit = 1'b0;
        next_s.zc_hit = 1'b0;
        next_s.step = 3'h0;
        if (s.stop_req || stop || s.mode == ASQ_ONCE) begin
          next_s.st = ASQ_IDLE;
        end else if (s.mode == ASQ_TRIG) begin
          next_s.st = ASQ_ARMED;
        end else begin
          next_s.st = ASQ_START;
        end
      end
      default: next_s.st = ASQ_IDLE;
    endcase
    // A stop mid-scan lets the whole scan finish first; the halt comes at scan end
    if (stop && (s.st == ASQ_START || s.st == ASQ_WAIT)) begin
      next_s.stop_req = 1'b1;
    end

    // Bus answer, one cycle after the request
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    next_s.rdat = 32'h0;
    unique case (wb_adr_i)
      `ASQ_OFF_CTRL: next_s.rdat = {21'h0, s.len, 5'h0, s.simult, s.mode};
      `ASQ_OFF_STAT: next_s.rdat = {30'h0, s.st == ASQ_ARMED,
                                    s.st != ASQ_IDLE && s.st != ASQ_ARMED};
      `ASQ_OFF_ISR:   next_s.rdat = {29'h0, s.isr};
      `ASQ_OFF_IMR:   next_s.rdat = {29'h0, s.imr};
      `ASQ_OFF_LIST:  next_s.rdat = {8'h0, s.list};
      `ASQ_OFF_ZCSEL: next_s.rdat = {16'h0, s.zcsel};
      `ASQ_OFF_LIMLO: next_s.rdat = {24'h0, s.limlo};
      `ASQ_OFF_LIMHI: next_s.rdat = {24'h0, s.limhi};
      `ASQ_OFF_ZCST:  next_s.rdat = {24'h0, s.zcst};
      default: begin
        if (in_bank(wb_adr_i, `ASQ_BANK_RES)) begin
          next_s.rdat = {20'h0, s.result[widx]};
        end else if (in_bank(wb_adr_i, `ASQ_BANK_LOW)) begin
          next_s.rdat = {20'h0, s.low[widx]};
        end else if (in_bank(wb_adr_i, `ASQ_BANK_HIGH)) begin
          next_s.rdat = {20'h0, s.high[widx]};
        end
      end
    endcase
    next_s.irq = |(next_s.isr & next_s.imr);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.list <= `ASQ_RST_LIST;
      for (int k = 0; k < `ASQ_NUM_CH; k++) begin
        s.low[k] <= `ASQ_RST_LOW;
        s.high[k] <= `ASQ_RST_HIGH;
      end
    end else begin
      s <= next_s;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign irq_o = s.irq;
  assign sh_a_ch_o = sel_w[0];
  assign sh_a_sample_o = sample_w[0];
  assign sh_b_ch_o = sel_w[1];
  assign sh_b_sample_o = sample_w[1];

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_result_slot: assert property (
    rvalid_w[0] && s.pend[0] |=> s.result[$past(rslot_w[0])] ==
      $past(rdata_w[0]))
    else $error("Result not stored in its slot");
  chk_seq_order: assert property (
    s.st == ASQ_START && !s.simult |=>
      s.start_ch[s.list[s.step][2]] == s.list[s.step])
    else $error("Sequential scan left list order");
  chk_port_pick: assert property (
    s.st == ASQ_START && !s.simult |=>
      s.start == ($past(ch[2]) ? 2'h2 : 2'h1))
    else $error("Wrong converter for the input");
  chk_simul_both: assert property (
    s.st == ASQ_START && s.simult |=> s.start == 2'h3 ##1 sample_w == 2'h3)
    else $error("Simultaneous step did not sample both");
  chk_mode_once: assert property (
    s.st == ASQ_END && s.mode == ASQ_ONCE |=> s.st == ASQ_IDLE)
    else $error("Single scan did not halt");
  chk_mode_trig: assert property (
    s.st == ASQ_END && s.mode == ASQ_TRIG && !s.stop_req && !stop
      |=> s.st == ASQ_ARMED)
    else $error("Triggered scan did not rearm");
  chk_mode_loop: assert property (
    s.st == ASQ_END && s.mode == ASQ_LOOP && !s.stop_req && !stop
      |=> s.st == ASQ_START && s.step == 3'h0)
    else $error("Repeated scan did not restart");
  chk_limit_flag: assert property (
    s.st == ASQ_END && s.out_hit |=> s.isr[`ASQ_ISR_LIM] && !s.out_hit)
    else $error("Limit event not flagged at scan end");
  chk_zc_flag: assert property (
    s.st == ASQ_END && s.zc_hit |=> s.isr[`ASQ_ISR_ZC])
    else $error("Zero crossing not flagged at scan end");
  chk_irq_level: assert property (
    ##1 irq_o == |(s.isr & s.imr))
    else $error("Interrupt level disagrees with status");
  chk_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held longer than one cycle");

  cov_single_scan: cover property (
    s.st == ASQ_END && s.mode == ASQ_ONCE ##1 s.st == ASQ_IDLE);
  cov_simul_scan: cover property (s.st == ASQ_END && s.simult);
  cov_trig_start: cover property (s.st == ASQ_ARMED ##1 s.st == ASQ_START);
  cov_limit_irq: cover property (s.isr[`ASQ_ISR_LIM] && irq_o);
endmodule : asq_top
`default_nettype wire

// ===== verification/asq_adc_model.sv
// Behavioural converter port: holds the sampled input, answers after LAT
`default_nettype none
module asq_adc_model #(
  parameter int LAT = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Sample request
  input  wire logic             sample_i,
  input  wire logic [2:0]       ch_i,
  // Conversion answer
  output logic                  done_o,
  output asq_pkg::asq_res_t     data_o
);
  import asq_pkg::*;
  logic [2:0] ch;
  int         cnt;
  // ***************************************************
  // Conversion timing
  // ***************************************************
  // Outside the done cycle the data bus toggles, so stale data never matches
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (rst_i) begin
      cnt    <= 0;
      data_o <= 12'hAAA;
    end else if (sample_i) begin
      ch  <= ch_i;
      cnt <= LAT;
    end else if (cnt == 1) begin
      cnt    <= 0;
      done_o <= 1'b1;
      data_o <= {ch, 9'h055};
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : asq_adc_model
`default_nettype wire

// ===== verification/tb_asq_top.sv
// Self-checking bench of the scan sequencer
`default_nettype none
`include "asq_map.svh"
module tb_asq_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asq_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] v;} asq_row_s;
  logic        clk_i, rst_i, cyc, stb, we, trig, ack, irq;
  logic        a_smp, b_smp, a_done, b_done;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, isr, dat_o;
  logic [2:0]  a_ch, b_ch;
  asq_res_t    a_dat, b_dat;
  int          fails, checks_done, na, nb, solo, cyc_n;
  asq_row_s    rows [0:9] = '{'{8'h00, 0}, '{8'h04, 0}, '{8'h08, 0},
    '{8'h0C, 0}, '{8'h10, 32'hFAC688}, '{8'h14, 0}, '{8'h40, 0},
    '{8'h60, 0}, '{8'h9C, 32'hFFF}, '{8'h3C, 0}};
  asq_top i_asq_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .trig_i(trig),
    .sh_a_ch_o(a_ch), .sh_a_sample_o(a_smp), .adc_a_done_i(a_done),
    .adc_a_data_i(a_dat), .sh_b_ch_o(b_ch), .sh_b_sample_o(b_smp),
    .adc_b_done_i(b_done), .adc_b_data_i(b_dat), .irq_o(irq));
  // Port A answers promptly, port B slowly
  asq_adc_model #(.LAT(2)) i_asq_adc_model_a (.clk_i(clk_i),
    .rst_i(rst_i), .sample_i(a_smp), .ch_i(a_ch), .done_o(a_done),
    .data_o(a_dat));
  asq_adc_model #(.LAT(9)) i_asq_adc_model_b (.clk_i(clk_i),
    .rst_i(rst_i), .sample_i(b_smp), .ch_i(b_ch), .done_o(b_done),
    .data_o(b_dat));
  // ***************************************************
  // Clock, timeout and sample monitor
  // ***************************************************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (a_smp === 1'b1) na++;
    if (b_smp === 1'b1) nb++;
    if (a_smp !== b_smp) solo++;
    if (cyc_n == 20000) begin
      fails++;
      test_done;
    end
  end
  // ***************************************************
  // Tasks
  // ***************************************************
  function automatic logic [31:0] val(input int c);
    return {20'h0, c[2:0], 9'h055};
  endfunction : val
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 0);
    chk($sformatf("reg %h", a), rdat, e);
  endtask : rd_chk
  task go(input logic [31:0] c);
    wb(1'b1, `ASQ_OFF_ISR, 32'h7);
    wb(1'b1, `ASQ_OFF_CTRL, c | 32'h10);
  endtask : go
  // Polls the done flag; a scan that never ends falls to the timeout
  task wait_done;
    isr = 0;
    while (isr[0] !== 1'b1) begin
      wb(1'b0, `ASQ_OFF_ISR, 0);
      isr = rdat;
    end
  endtask : wait_done
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    {cyc, stb, we, trig, adr, sel, wdat} = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) rd_chk(rows[i].a, rows[i].v);
    na = 0; nb = 0;
    go(32'h0700); wait_done;
    chk("isr", isr, 1);
    chk("irq", irq, 0);
    for (int k = 0; k < 8; k++) rd_chk(8'h40 + 4 * k, val(k));
    chk("na", na, 4); chk("nb", nb, 4);
    rd_chk(`ASQ_OFF_STAT, 0);
    wb(1'b1, `ASQ_OFF_LIST, 32'h53977);
    na = 0; nb = 0;
    go(32'h0300); wait_done;
    for (int k = 0; k < 4; k++) rd_chk(8'h40 + 4 * k, val(7 - k));
    chk("na", na, 0); chk("nb", nb, 4);
    // Distinct inputs on the two ports in every step
    wb(1'b1, `ASQ_OFF_LIST, 32'hFAC688);
    na = 0; solo = 0;
    go(32'h0104); wait_done;
    chk("solo", solo, 0); chk("na", na, 2);
    rd_chk(8'h40, val(0)); rd_chk(8'h44, val(1));
    rd_chk(8'h50, val(4)); rd_chk(8'h54, val(5));
    wb(1'b1, `ASQ_BANK_LOW, 32'h100);
    wb(1'b1, `ASQ_BANK_HIGH + 8'h4, 32'h100);
    wb(1'b1, `ASQ_OFF_IMR, 32'h2);
    go(32'h0100); wait_done;
    chk("isr", isr, 3); chk("irq", irq, 1);
    rd_chk(`ASQ_OFF_LIMLO, 1); rd_chk(`ASQ_OFF_LIMHI, 2);
    wb(1'b1, `ASQ_OFF_LIMLO, 1);
    rd_chk(`ASQ_OFF_LIMLO, 0);
    wb(1'b1, `ASQ_OFF_ISR, 32'h7);
    repeat (2) @(posedge clk_i);
    chk("irq", irq, 0);
    wb(1'b1, `ASQ_OFF_ZCSEL, 32'h2);
    wb(1'b1, `ASQ_OFF_IMR, 32'h4);
    wb(1'b1, `ASQ_OFF_LIST, 32'hFAC68C);
    go(32'h0); wait_done;
    chk("isr", isr, 5); chk("irq", irq, 1);
    rd_chk(`ASQ_OFF_ZCST, 1);
    na = 0; nb = 0;
    go(32'h1);
    rd_chk(`ASQ_OFF_STAT, 2);
    repeat (20) @(posedge clk_i);
    chk("idle", na + nb, 0);
    trig <= 1'b1;
    wait_done;
    trig <= 1'b0;
    rd_chk(`ASQ_OFF_STAT, 2); chk("one", na + nb, 1);
    wb(1'b1, `ASQ_OFF_CTRL, 32'h21);
    rd_chk(`ASQ_OFF_STAT, 0);
    go(32'h2); wait_done;
    wb(1'b1, `ASQ_OFF_ISR, 32'h7);
    wait_done;
    wb(1'b1, `ASQ_OFF_CTRL, 32'h22);
    for (int i = 0; i < 50 && rdat !== 0; i++) wb(1'b0, `ASQ_OFF_STAT, 0);
    rd_chk(`ASQ_OFF_STAT, 0);
    // Slot 0 falls from 0x855 to 0x055 (also below its low limit), then rises
    for (int z = 1; z < 4; z += 2) begin
      wb(1'b1, `ASQ_OFF_ZCSEL, z);
      wb(1'b1, `ASQ_OFF_LIST, z == 1 ? 32'hFAC688 : 32'hFAC68C);
      wb(1'b1, `ASQ_OFF_ZCST, 32'hFF);
      go(32'h0); wait_done;
      chk("isr", isr, z == 1 ? 7 : 5);
      rd_chk(`ASQ_OFF_ZCST, 1);
    end
    // Reset in the middle of a repeated scan
    go(32'h2);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`ASQ_OFF_STAT, 0); rd_chk(`ASQ_OFF_ISR, 0);
    rd_chk(`ASQ_OFF_LIST, 32'hFAC688);
    chk("irq", irq, 0);
    test_done;
  end
endmodule : tb_asq_top
`default_nettype wire
